// ### dcs_defs.svh
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH

// request bus width and idle level (low-true lines rest high)
`define DCS_RQ_W        12
`define DCS_WORD_W      24
`define DCS_RQ_IDLE     12'hfff
`define DCS_MCLK_RST    1'b1

// command word fields, sample 0 carries bits 11..0, sample 1 bits 23..12
`define DCS_F_OP_LSB    0
`define DCS_F_OP_MSB    3
`define DCS_F_BANK_LSB  4
`define DCS_F_BANK_MSB  6
`define DCS_F_IDX_LSB   7
`define DCS_F_IDX_MSB   8

// bank set selector bit within the bank number
`define DCS_SET_BIT     2

// timing bins
`define DCS_BIN_A       2'h0
`define DCS_BIN_B       2'h1
`define DCS_BIN_C       2'h2

// spacing minimums in master clock cycles, bins a / b / c
`define DCS_CW          5
`define DCS_RDP_A       5'h03
`define DCS_RDP_B       5'h04
`define DCS_RDP_C       5'h04
`define DCS_WRP_A       5'h0a
`define DCS_WRP_B       5'h0c
`define DCS_WRP_C       5'h0c
`define DCS_DR_A        5'h00
`define DCS_DR_B        5'h00
`define DCS_DR_C        5'h07
`define DCS_DP_A        5'h07
`define DCS_DP_B        5'h09
`define DCS_DP_C        5'h09
`define DCS_SPC_A       5'h10
`define DCS_SPC_B       5'h14
`define DCS_SPC_C       5'h18
`define DCS_DWR_A       5'h09
`define DCS_DWR_B       5'h0a
`define DCS_DWR_C       5'h0a
`define DCS_DWR_D       5'h02
`define DCS_CWD         5'h03
`define DCS_PP          5'h04
`define DCS_PP_D        5'h01
`define DCS_RR          5'h04
`define DCS_RR_D        5'h04

`endif

// ### dcs_pkg.sv
`include "dcs_defs.svh"

package dcs_pkg;

   // request opcodes carried in the command word
   typedef enum logic [3:0] {
      DCS_OP_NOP,
      DCS_OP_ACT,
      DCS_OP_RD,
      DCS_OP_WR,
      DCS_OP_WRM,
      DCS_OP_PRE,
      DCS_OP_REFA,
      DCS_OP_REFI,
      DCS_OP_REFP,
      DCS_OP_SPC
   } dcs_op_t;

   typedef logic [`DCS_CW-1:0]     dcs_cnt_t;
   typedef logic [`DCS_WORD_W-1:0] dcs_word_t;

endpackage : dcs_pkg

// ### dcs_rq_if.sv
`timescale 1ns/100ps
`default_nettype none

`include "dcs_defs.svh"

// master clock pair and low-true request bus, controller to device
interface dcs_rq_if;
   logic                 mclk_t;
   logic                 mclk_c;
   logic [`DCS_RQ_W-1:0] rq_n;

   modport ctl (output mclk_t, output mclk_c, output rq_n);
   modport dev (input mclk_t, input mclk_c, input rq_n);
endinterface : dcs_rq_if

`default_nettype wire

// ### dcs_ctl.sv
`timescale 1ns/100ps
`default_nettype none

`include "dcs_defs.svh"

// Functional notes
// - read to precharge same bank spacing
// - write to precharge same bank spacing
// - write data to read same bank
// - write data to precharge same bank
// - special row commands spaced apart
// - refresh class then special row spacing
// - special row then refresh class spacing
// - special and refresh groups checked as classes
// - cross-set write-read avoids 3,5,7 below minimum
// - cross-set precharges use relaxed minimum
// - cross-set activates use own minimum
// - true line falling is primary reference
// - cycles start at primary crossing
// - request lines driven low for one
// - two samples per line per cycle
module dcs_ctl #(
   parameter int HALF_CYC = 1                    // system clocks per master clock half
) (
   input  wire logic             SYS_CLK,        // system clock
   input  wire logic             RSTN,           // synchronous reset, active low
   input  wire logic [1:0]       TIMING_BIN,     // selected timing bin
   input  wire logic             CMD_VALID,      // command waiting
   input  wire dcs_pkg::dcs_op_t CMD_OP,         // command opcode
   input  wire logic [2:0]       CMD_BANK,       // target bank
   input  wire logic [1:0]       CMD_IDX,        // special row index 0..2
   output var  logic             CMD_ACK,        // one-cycle pulse, command sent
   dcs_rq_if.ctl                 link            // request link to device
);
   import dcs_pkg::*;

   generate
      if (HALF_CYC < 1 || HALF_CYC > 256)
      begin : g_bad_half
         $error("HALF_CYC must be 1 to 256");
      end
   endgenerate

   localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

   // pick a bin's minimum
   function automatic dcs_cnt_t pick(input logic [1:0] bin, input dcs_cnt_t a,
                                     input dcs_cnt_t b, input dcs_cnt_t c);
      case (bin)
         `DCS_BIN_A: pick = a;
         `DCS_BIN_B: pick = b;
         default:    pick = c;
      endcase
   endfunction : pick

   // saturating decrement of a spacing counter
   function automatic dcs_cnt_t dec(input dcs_cnt_t x);
      dec = (x == '0) ? x : dcs_cnt_t'(x - 1'b1);
   endfunction : dec

   logic [7:0]           hdiv;
   logic                 clk_t;
   logic                 clk_c;
   logic [`DCS_RQ_W-1:0] rq_n;
   logic [`DCS_RQ_W-1:0] word_hi;
   dcs_cnt_t             rdp [8];
   dcs_cnt_t             wrp [8];
   dcs_cnt_t             wdr [8];
   dcs_cnt_t             spc;
   dcs_cnt_t             ref2spc;
   dcs_cnt_t             pp;
   dcs_cnt_t             rr;
   dcs_cnt_t             wr;
   logic                 pre_set;
   logic                 act_set;
   logic                 wr_set;

   logic [7:0]           next_hdiv;
   logic                 next_clk_t;
   logic                 next_clk_c;
   logic [`DCS_RQ_W-1:0] next_rq_n;
   logic [`DCS_RQ_W-1:0] next_word_hi;
   logic                 next_ack;
   dcs_cnt_t             next_rdp [8];
   dcs_cnt_t             next_wrp [8];
   dcs_cnt_t             next_wdr [8];
   dcs_cnt_t             next_spc;
   dcs_cnt_t             next_ref2spc;
   dcs_cnt_t             next_pp;
   dcs_cnt_t             next_rr;
   dcs_cnt_t             next_wr;
   logic                 next_pre_set;
   logic                 next_act_set;
   logic                 next_wr_set;

   dcs_cnt_t             rdp_v;
   dcs_cnt_t             wrp_v;
   dcs_cnt_t             dr_v;
   dcs_cnt_t             dp_v;
   dcs_cnt_t             spc_v;
   dcs_cnt_t             dwr_v;
   dcs_word_t            word;
   dcs_cnt_t             el;
   logic                 cset;
   logic                 is_ref;
   logic                 ok;

   // minimums for the selected bin
   assign rdp_v = pick(TIMING_BIN, `DCS_RDP_A, `DCS_RDP_B, `DCS_RDP_C);
   assign wrp_v = pick(TIMING_BIN, `DCS_WRP_A, `DCS_WRP_B, `DCS_WRP_C);
   assign dr_v  = pick(TIMING_BIN, `DCS_DR_A, `DCS_DR_B, `DCS_DR_C);
   assign dp_v  = pick(TIMING_BIN, `DCS_DP_A, `DCS_DP_B, `DCS_DP_C);
   assign spc_v = pick(TIMING_BIN, `DCS_SPC_A, `DCS_SPC_B, `DCS_SPC_C);
   assign dwr_v = pick(TIMING_BIN, `DCS_DWR_A, `DCS_DWR_B, `DCS_DWR_C);

   // link pins straight from flops
   assign link.mclk_t = clk_t;
   assign link.mclk_c = clk_c;
   assign link.rq_n   = rq_n;

   // clock divider, request drive and spacing counters
   always_comb
   begin
      next_hdiv    = hdiv;
      next_clk_t   = clk_t;
      next_clk_c   = clk_c;
      next_rq_n    = rq_n;
      next_word_hi = word_hi;
      next_ack     = 1'b0;
      next_rdp     = rdp;
      next_wrp     = wrp;
      next_wdr     = wdr;
      next_spc     = spc;
      next_ref2spc = ref2spc;
      next_pp      = pp;
      next_rr      = rr;
      next_wr      = wr;
      next_pre_set = pre_set;
      next_act_set = act_set;
      next_wr_set  = wr_set;
      word         = '0;
      el           = '0;
      cset         = CMD_BANK[`DCS_SET_BIT];
      is_ref       = 1'b0;
      ok           = 1'b0;
      if (hdiv != HALF_LAST)
      begin
         next_hdiv = 8'(hdiv + 1'b1);
      end
      else
      begin
         next_hdiv  = '0;
         next_clk_t = ~clk_t;
         next_clk_c = clk_t;
         if (clk_t)
         begin
            // primary crossing: a new cycle starts, counters age by one
            for (int b = 0; b < 8; b++)
            begin
               next_rdp[b] = dec(rdp[b]);
               next_wrp[b] = dec(wrp[b]);
               next_wdr[b] = dec(wdr[b]);
            end
            next_spc     = dec(spc);
            next_ref2spc = dec(ref2spc);
            next_pp      = dec(pp);
            next_rr      = dec(rr);
            next_wr      = dec(wr);
            el           = dcs_cnt_t'(dwr_v - next_wr);
            is_ref       = (CMD_OP == DCS_OP_REFA) || (CMD_OP == DCS_OP_REFI) ||
                           (CMD_OP == DCS_OP_REFP);
            // legality against the aged counters
            case (CMD_OP)
               DCS_OP_RD:
                  ok = (next_wdr[CMD_BANK] == '0) &&
                       ((next_wr == '0) ||
                        ((cset != wr_set) && (el >= `DCS_DWR_D) &&
                         (el != 5'h03) && (el != 5'h05) && (el != 5'h07)));
               DCS_OP_PRE:
                  ok = (next_rdp[CMD_BANK] == '0) &&
                       (next_wrp[CMD_BANK] == '0) &&
                       ((cset == pre_set) ? (next_pp == '0) :
                        (next_pp <= dcs_cnt_t'(`DCS_PP - `DCS_PP_D)));
               DCS_OP_REFP:
                  ok = (next_spc == '0) &&
                       ((cset == pre_set) ? (next_pp == '0) :
                        (next_pp <= dcs_cnt_t'(`DCS_PP - `DCS_PP_D)));
               DCS_OP_ACT:
                  ok = (cset == act_set) ? (next_rr == '0) :
                       (next_rr <= dcs_cnt_t'(`DCS_RR - `DCS_RR_D));
               DCS_OP_REFA, DCS_OP_REFI:
                  ok = (next_spc == '0) &&
                       ((cset == act_set) ? (next_rr == '0) :
                        (next_rr <= dcs_cnt_t'(`DCS_RR - `DCS_RR_D)));
               DCS_OP_SPC:
                  ok = (next_spc == '0) && (next_ref2spc == '0) &&
                       (CMD_IDX <= 2'h2);
               DCS_OP_WR, DCS_OP_WRM:
                  ok = 1'b1;
               default:
                  ok = 1'b0;
            endcase
            word[`DCS_F_OP_MSB:`DCS_F_OP_LSB]     = CMD_OP;
            word[`DCS_F_BANK_MSB:`DCS_F_BANK_LSB] = CMD_BANK;
            word[`DCS_F_IDX_MSB:`DCS_F_IDX_LSB]   = CMD_IDX;
            if (CMD_VALID && ok)
            begin
               next_ack     = 1'b1;
               next_rq_n    = ~word[`DCS_RQ_W-1:0];
               next_word_hi = word[`DCS_WORD_W-1:`DCS_RQ_W];
               // load the counters this command governs
               case (CMD_OP)
                  DCS_OP_RD:
                     next_rdp[CMD_BANK] = rdp_v;
                  DCS_OP_WR, DCS_OP_WRM:
                  begin
                     // data starts a write delay after the command
                     next_wrp[CMD_BANK] = (wrp_v > dcs_cnt_t'(`DCS_CWD + dp_v)) ?
                                          wrp_v : dcs_cnt_t'(`DCS_CWD + dp_v);
                     // bins without a data-to-read limit load zero
                     next_wdr[CMD_BANK] = (dr_v == '0) ? '0 : dcs_cnt_t'(`DCS_CWD + dr_v);
                     next_wr            = dwr_v;
                     next_wr_set        = cset;
                  end
                  DCS_OP_PRE:
                  begin
                     next_pp      = `DCS_PP;
                     next_pre_set = cset;
                  end
                  DCS_OP_ACT:
                  begin
                     next_rr      = `DCS_RR;
                     next_act_set = cset;
                  end
                  DCS_OP_SPC:
                     next_spc = spc_v;
                  default:
                  begin
                     next_ref2spc = is_ref ? spc_v : ref2spc;
                     if (CMD_OP == DCS_OP_REFP)
                     begin
                        next_pp      = `DCS_PP;
                        next_pre_set = cset;
                     end
                     else
                     begin
                        next_rr      = `DCS_RR;
                        next_act_set = cset;
                     end
                  end
               endcase
            end
            else
            begin
               next_rq_n    = `DCS_RQ_IDLE;
               next_word_hi = '0;
            end
         end
         else
         begin
            // secondary crossing: second half of the word
            next_rq_n = ~word_hi;
         end
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         hdiv    <= '0;
         clk_t   <= `DCS_MCLK_RST;
         clk_c   <= ~`DCS_MCLK_RST;
         rq_n    <= `DCS_RQ_IDLE;
         word_hi <= '0;
         CMD_ACK <= 1'b0;
         for (int b = 0; b < 8; b++)
         begin
            rdp[b] <= '0;
            wrp[b] <= '0;
            wdr[b] <= '0;
         end
         spc     <= '0;
         ref2spc <= '0;
         pp      <= '0;
         rr      <= '0;
         wr      <= '0;
         pre_set <= 1'b0;
         act_set <= 1'b0;
         wr_set  <= 1'b0;
      end
      else
      begin
         hdiv    <= next_hdiv;
         clk_t   <= next_clk_t;
         clk_c   <= next_clk_c;
         rq_n    <= next_rq_n;
         word_hi <= next_word_hi;
         CMD_ACK <= next_ack;
         rdp     <= next_rdp;
         wrp     <= next_wrp;
         wdr     <= next_wdr;
         spc     <= next_spc;
         ref2spc <= next_ref2spc;
         pp      <= next_pp;
         rr      <= next_rr;
         wr      <= next_wr;
         pre_set <= next_pre_set;
         act_set <= next_act_set;
         wr_set  <= next_wr_set;
      end
   end

endmodule : dcs_ctl

`default_nettype wire

// ### dcs_dev.sv
`timescale 1ns/100ps
`default_nettype none

`include "dcs_defs.svh"

module dcs_dev (
   input  wire logic              SYS_CLK,       // system clock
   input  wire logic              RSTN,          // synchronous reset, active low
   dcs_rq_if.dev                  link,          // request link from controller
   output var  dcs_pkg::dcs_word_t RQ_WORD,      // captured word, sample 1 high
   output var  logic              RQ_VALID,      // one-cycle pulse, new word
   output var  dcs_pkg::dcs_op_t  RQ_OP,         // decoded opcode
   output var  logic [2:0]        RQ_BANK,       // decoded bank
   output var  logic [1:0]        RQ_IDX,        // decoded special row index
   output var  logic              RQ_REFRESH,    // refresh class command
   output var  logic              RQ_SPECIAL     // special row group command
);
   import dcs_pkg::*;

   logic                 prev_t;
   logic [`DCS_RQ_W-1:0] s0;
   logic                 next_prev_t;
   logic [`DCS_RQ_W-1:0] next_s0;
   dcs_word_t            next_word;
   logic                 next_valid;
   dcs_op_t              next_op;
   logic [2:0]           next_bank;
   logic [1:0]           next_idx;
   logic                 next_refresh;
   logic                 next_special;
   logic                 primary;
   logic                 secondary;

   // edge detection against the previous true-line level; the pins are
   // synchronous to SYS_CLK, so no extra synchroniser is needed
   always_comb
   begin
      primary      = prev_t && !link.mclk_t && link.mclk_c;
      secondary    = !prev_t && link.mclk_t && !link.mclk_c;
      next_prev_t  = link.mclk_t;
      next_s0      = s0;
      next_word    = RQ_WORD;
      next_valid   = 1'b0;
      next_op      = RQ_OP;
      next_bank    = RQ_BANK;
      next_idx     = RQ_IDX;
      next_refresh = RQ_REFRESH;
      next_special = RQ_SPECIAL;
      if (primary)
      begin
         next_s0 = ~link.rq_n;
      end
      if (secondary)
      begin
         // word completes half a cycle after the primary crossing
         next_word    = {~link.rq_n, s0};
         next_valid   = 1'b1;
         next_op      = dcs_op_t'(s0[`DCS_F_OP_MSB:`DCS_F_OP_LSB]);
         next_bank    = s0[`DCS_F_BANK_MSB:`DCS_F_BANK_LSB];
         next_idx     = s0[`DCS_F_IDX_MSB:`DCS_F_IDX_LSB];
         next_refresh = (next_op == DCS_OP_REFA) || (next_op == DCS_OP_REFI) ||
                        (next_op == DCS_OP_REFP);
         next_special = (next_op == DCS_OP_SPC) && (next_idx <= 2'h2);
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         prev_t     <= `DCS_MCLK_RST;
         s0         <= '0;
         RQ_WORD    <= '0;
         RQ_VALID   <= 1'b0;
         RQ_OP      <= DCS_OP_NOP;
         RQ_BANK    <= '0;
         RQ_IDX     <= '0;
         RQ_REFRESH <= 1'b0;
         RQ_SPECIAL <= 1'b0;
      end
      else
      begin
         prev_t     <= next_prev_t;
         s0         <= next_s0;
         RQ_WORD    <= next_word;
         RQ_VALID   <= next_valid;
         RQ_OP      <= next_op;
         RQ_BANK    <= next_bank;
         RQ_IDX     <= next_idx;
         RQ_REFRESH <= next_refresh;
         RQ_SPECIAL <= next_special;
      end
   end

endmodule : dcs_dev

`default_nettype wire

// ### dcs_properties.sv
`timescale 1ns/100ps
`default_nettype none

module dcs_properties (
   input wire logic               SYS_CLK,   // system clock
   input wire logic               RSTN,      // synchronous reset, active low
   input wire logic               mclk_t,    // master clock true line
   input wire logic               mclk_c,    // master clock complement
   input wire logic [11:0]        rq_n,      // low-true request bus
   input wire logic               CMD_ACK,   // controller accept pulse
   input wire logic               RQ_VALID,  // device word pulse
   input wire dcs_pkg::dcs_word_t RQ_WORD    // device captured word
);
   import dcs_pkg::*;

   logic [3:0] wire_op;

   // opcode on the wire, turned back to true polarity
   assign wire_op = ~rq_n[3:0];

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RSTN);

   // a word goes out only at the primary crossing
   sequence s_primary;
      $fell(mclk_t) && mclk_c;
   endsequence
   sequence s_spc;
      CMD_ACK && (wire_op == DCS_OP_SPC);
   endsequence
   sequence s_ref;
      CMD_ACK && (wire_op inside {DCS_OP_REFA, DCS_OP_REFI, DCS_OP_REFP});
   endsequence
   // both classes count alike for spacing
   sequence s_group;
      CMD_ACK && (wire_op inside {DCS_OP_SPC, DCS_OP_REFA, DCS_OP_REFI, DCS_OP_REFP});
   endsequence

   clk_pair_a: assert property (mclk_c == ~mclk_t)
      else $error("clock lines not complementary");
   ack_primary_a: assert property (CMD_ACK |-> s_primary)
      else $error("command sent off the primary crossing");
   idle_word_a: assert property ($fell(mclk_t) && !CMD_ACK |-> rq_n == 12'hfff)
      else $error("idle slot does not rest high");
   half_idle_a: assert property ($rose(mclk_t) |-> rq_n == 12'hfff)
      else $error("second half word not zero");
   word_form_a: assert property (CMD_ACK |-> rq_n[11:9] == 3'h7 && rq_n[3:0] != 4'hf)
      else $error("sent word malformed");
   valid_lag_a: assert property (s_primary |-> ##2 RQ_VALID)
      else $error("device word late or missing");
   word_capture_a: assert property (s_primary |-> ##2 RQ_WORD == {~$past(rq_n, 1), ~$past(rq_n, 2)})
      else $error("device captured wrong samples");
   valid_pulse_a: assert property (RQ_VALID |=> !RQ_VALID)
      else $error("device word pulse too long");
   spc_gap_a: assert property (s_spc |-> not (##[1:31] s_group))
      else $error("special row followed too soon");
   ref_spc_gap_a: assert property (s_ref |-> not (##[1:31] s_spc))
      else $error("refresh followed by special row too soon");
endmodule : dcs_properties

`default_nettype wire

// ### dram_cmd_spacing_rq_sampler_test.sv
`timescale 1ns/100ps
`default_nettype none

module dram_cmd_spacing_rq_sampler_test;
   import dcs_pkg::*;

   logic       sys_clk;
   logic       rstn;
   logic [1:0] timing_bin;
   logic       cmd_valid;
   dcs_op_t    cmd_op;
   logic [2:0] cmd_bank;
   logic [1:0] cmd_idx;
   logic       cmd_ack;
   dcs_word_t  rq_word;
   logic       rq_valid;
   dcs_op_t    rq_op;
   logic [2:0] rq_bank;
   logic [1:0] rq_idx;
   logic       rq_refresh;
   logic       rq_special;
   int         n_errors;
   int         checks_done;
   int         cyc;
   dcs_word_t  exp_q[$];

   dcs_rq_if link_if();

   dcs_ctl dcs_ctl_inst (.SYS_CLK(sys_clk), .RSTN(rstn), .TIMING_BIN(timing_bin),
      .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_BANK(cmd_bank), .CMD_IDX(cmd_idx),
      .CMD_ACK(cmd_ack), .link(link_if));
   dcs_dev dcs_dev_inst (.SYS_CLK(sys_clk), .RSTN(rstn), .link(link_if), .RQ_WORD(rq_word),
      .RQ_VALID(rq_valid), .RQ_OP(rq_op), .RQ_BANK(rq_bank), .RQ_IDX(rq_idx),
      .RQ_REFRESH(rq_refresh), .RQ_SPECIAL(rq_special));
   dcs_properties dcs_properties_inst (.SYS_CLK(sys_clk), .RSTN(rstn),
      .mclk_t(link_if.mclk_t), .mclk_c(link_if.mclk_c), .rq_n(link_if.rq_n),
      .CMD_ACK(cmd_ack), .RQ_VALID(rq_valid), .RQ_WORD(rq_word));

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // cycle count, read at falling edges where it is settled
   initial cyc = 0;
   always @(posedge sys_clk) cyc <= cyc + 1;

   task automatic chk_word(input string what, input dcs_word_t exp, input dcs_word_t got);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   task automatic chk_gap(input string what, input int exp, input int got);
      checks_done++;
      if (got != exp)
      begin
         n_errors++;
         $display("FAIL %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_gap

   task automatic test_done;
      if (n_errors == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   // holds the request until accepted; fields change in the accept cycle
   task automatic send(input dcs_op_t op, input logic [2:0] bank, input logic [1:0] idx,
                       output int t);
      int n;
      cmd_op = op;
      cmd_bank = bank;
      cmd_idx = idx;
      cmd_valid = 1'b1;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (cmd_ack !== 1'b1 && n < 400);
      if (n >= 400)
         chk_gap("command accept wait", 0, n);
      t = cyc;
      exp_q.push_back({15'h0, idx, bank, op});
   endtask : send

   task automatic idle(input int n);
      cmd_valid = 1'b0;
      cmd_op = DCS_OP_NOP;
      repeat (n) @(negedge sys_clk);
   endtask : idle

   // second command offered d master cycles late; gap counted in master cycles
   task automatic run_pair(input dcs_op_t op1, input logic [2:0] b1, input logic [1:0] i1,
                           input dcs_op_t op2, input logic [2:0] b2, input logic [1:0] i2,
                           input int d, input int ea, input int eb, input int ec);
      int t1;
      int t2;
      int e;
      e = (timing_bin == 2'h0) ? ea : (timing_bin == 2'h1) ? eb : ec;
      send(op1, b1, i1, t1);
      if (d > 0)
         idle(2 * d);
      send(op2, b2, i2, t2);
      idle(60);
      chk_gap("command spacing", e, (t2 - t1) / 2);
   endtask : run_pair

   // every device word checked against what was accepted, idle words against zero
   always @(negedge sys_clk)
   begin
      dcs_word_t e;
      if (rstn === 1'b1 && rq_valid === 1'b1)
      begin
         if (rq_op !== DCS_OP_NOP)
         begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 24'hxxxxxx;
            chk_word("captured word", e, rq_word);
            chk_word("decoded fields", e, {15'h0, rq_idx, rq_bank, rq_op});
            chk_word("refresh flag", 24'(e[3:0] inside {4'h6, 4'h7, 4'h8}), 24'(rq_refresh));
            chk_word("special flag", 24'(e[3:0] == 4'h9), 24'(rq_special));
         end
         else
            chk_word("idle word", 24'h000000, rq_word);
      end
   end

   initial
   begin
      int t0;
      int t;
      n_errors = 0;
      checks_done = 0;
      rstn = 1'b0;
      timing_bin = 2'h0;
      cmd_valid = 1'b0;
      cmd_op = DCS_OP_NOP;
      cmd_bank = 3'h0;
      cmd_idx = 2'h0;
      repeat (6) @(negedge sys_clk);
      rstn = 1'b1;
      // bin codes 2 and 3 both select the slowest bin
      for (int b = 0; b < 4; b++)
      begin
         timing_bin = 2'(b);
         idle(4);
         run_pair(DCS_OP_RD, 3'h0, 2'h0, DCS_OP_PRE, 3'h0, 2'h0, 0, 3, 4, 4);
         run_pair(DCS_OP_WR, 3'h1, 2'h0, DCS_OP_PRE, 3'h1, 2'h0, 0, 10, 12, 12);
         run_pair(DCS_OP_WRM, 3'h2, 2'h0, DCS_OP_PRE, 3'h2, 2'h0, 0, 10, 12, 12);
         run_pair(DCS_OP_WR, 3'h0, 2'h0, DCS_OP_RD, 3'h0, 2'h0, 0, 9, 10, 10);
         run_pair(DCS_OP_WR, 3'h0, 2'h0, DCS_OP_RD, 3'h4, 2'h0, 0, 2, 2, 2);
         run_pair(DCS_OP_WR, 3'h0, 2'h0, DCS_OP_RD, 3'h4, 2'h0, 2, 4, 4, 4);
         run_pair(DCS_OP_WRM, 3'h3, 2'h0, DCS_OP_RD, 3'h7, 2'h0, 4, 6, 6, 6);
         run_pair(DCS_OP_SPC, 3'h0, 2'h0, DCS_OP_SPC, 3'h0, 2'h1, 0, 16, 20, 24);
         run_pair(DCS_OP_REFA, 3'h0, 2'h0, DCS_OP_SPC, 3'h0, 2'h2, 0, 16, 20, 24);
         run_pair(DCS_OP_REFI, 3'h1, 2'h0, DCS_OP_SPC, 3'h0, 2'h0, 0, 16, 20, 24);
         run_pair(DCS_OP_SPC, 3'h0, 2'h1, DCS_OP_REFP, 3'h3, 2'h0, 0, 16, 20, 24);
         run_pair(DCS_OP_PRE, 3'h0, 2'h0, DCS_OP_PRE, 3'h4, 2'h0, 0, 1, 1, 1);
         run_pair(DCS_OP_PRE, 3'h0, 2'h0, DCS_OP_PRE, 3'h1, 2'h0, 0, 4, 4, 4);
         run_pair(DCS_OP_ACT, 3'h0, 2'h0, DCS_OP_ACT, 3'h5, 2'h0, 0, 4, 4, 4);
      end
      // reset in mid-run clears loaded spacing counters and parks the link
      send(DCS_OP_SPC, 3'h0, 2'h0, t);
      idle(4);
      rstn = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk_word("link in reset", {9'h0, cmd_ack, link_if.mclk_t, link_if.mclk_c, link_if.rq_n},
               24'h002fff);
      rstn = 1'b1;
      t0 = cyc;
      send(DCS_OP_SPC, 3'h0, 2'h1, t);
      chk_gap("accept after reset", 1, t - t0);
      idle(60);
      chk_gap("words not delivered", 0, exp_q.size());
      test_done();
   end

   // whole run is about 4700 cycles
   initial
   begin
      repeat (30000) @(posedge sys_clk);
      n_errors++;
      test_done();
   end
endmodule : dram_cmd_spacing_rq_sampler_test

`default_nettype wire
